//--- rtl/ctb_ca_term_ctrl.sv
// Command bus termination control: decodes strength, strap and overrides into termination states.
// Assumes the mode register fields arrive on mclk, and the strap and power-state pins with the
// controller's clock ca_clk; the termination outputs are produced in the ca_clk domain.
`timescale 1ns/1ps
`include "ctb_consts.svh"

////////////////////////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Strength field codes 1 to 6 select 240, 120, 80, 60, 48, 40 ohm.
// - Field resets disabled; disabled field turns all termination off.
// - Enabled command bus termination stays on in power-down and self refresh.
// - Strap low means CA signals are never terminated.
// - Strap high with field enabled terminates CA at the selected strength unless the disable bit is set.
// - Field enabled, strap low: clock and select follow forces; high: both on, CA unless disabled.
// - Strap state is left unchanged when entering power-down.
module ctb_ca_term_ctrl
   import ctb_pkg::*;
(
   // Core clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // Mode register fields, mclk domain
   input  wire ctb_pkg::ctb_code_t ca_term_value_field,
   input  wire logic         clock_term_force,
   input  wire logic         chip_select_term_force,
   input  wire logic         ca_term_disable,
   // Controller clock and pads
   input  wire logic         ca_clk,
   input  wire logic         ca_term_strap,
   input  wire logic         power_down,
   input  wire logic         self_refresh,
   // Configuration transfer status, mclk domain
   output logic              cfg_busy,
   // Termination states, ca_clk domain
   output logic              ca_term_on,
   output logic              ck_term_on,
   output logic              cs_term_on,
   output ctb_pkg::ctb_legs_t ca_term_leg_sel
);
   import ctb_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Core side: hold the configuration word and hand it over by toggle handshake

   ctb_xfer_e state;
   ctb_xfer_e next_state;
   ctb_word_t cfg_hold;
   ctb_word_t next_cfg_hold;
   logic      req_tgl;
   logic      next_req_tgl;
   logic      next_cfg_busy;
   logic      ack_sync;
   logic      ack_tgl;
   ctb_word_t cfg_word;

   assign cfg_word = {ca_term_disable, chip_select_term_force, clock_term_force, ca_term_value_field};

   // The held word only changes while no transfer is pending, so the link side
   // may sample all its bits at once after seeing the request toggle.
   always_comb begin
      next_state    = state;
      next_cfg_hold = cfg_hold;
      next_req_tgl  = req_tgl;
      case (state)
         CTB_IDLE: begin
            if (cfg_word != cfg_hold) begin
               next_cfg_hold = cfg_word;
               next_req_tgl  = ~req_tgl;
               next_state    = CTB_WAIT;
            end
         end
         CTB_WAIT: begin
            if (ack_sync == req_tgl) begin
               next_state = CTB_IDLE;
            end
         end
         default: begin
            next_state = CTB_IDLE;
         end
      endcase
      if (rst) begin
         next_state    = CTB_IDLE;
         next_cfg_hold = `CTB_CFG_RST;
         next_req_tgl  = 1'b0;
      end
      next_cfg_busy = (next_state == CTB_WAIT);
   end

   always_ff @(posedge mclk) begin
      state    <= next_state;
      cfg_hold <= next_cfg_hold;
      req_tgl  <= next_req_tgl;
      cfg_busy <= next_cfg_busy;
   end

   ctb_sync2 #(.W(1)) u_ack_sync (
      .clk (mclk),
      .rst (rst),
      .d   (ack_tgl),
      .q   (ack_sync)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Link side: reset, pads and request brought into ca_clk

   logic       lrst;
   logic [3:0] pad_sync;
   logic       strap_s;
   logic       pd_s;
   logic       sr_s;
   logic       req_sync;

   // Reset crosses as a level; the link clock must run for two edges to see it
   ctb_sync2 #(.W(1)) u_rst_sync (
      .clk (ca_clk),
      .rst (1'b0),
      .d   (rst),
      .q   (lrst)
   );

   ctb_sync2 #(.W(4)) u_pad_sync (
      .clk (ca_clk),
      .rst (lrst),
      .d   ({req_tgl, self_refresh, power_down, ca_term_strap}),
      .q   (pad_sync)
   );

   assign strap_s  = pad_sync[0];
   assign pd_s     = pad_sync[1];
   assign sr_s     = pad_sync[2];
   assign req_sync = pad_sync[3];

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Link side: current configuration and termination decode

   ctb_word_t cur;
   ctb_word_t next_cur;
   logic      next_ack_tgl;
   logic      next_ca_on;
   logic      next_ck_on;
   logic      next_cs_on;
   ctb_legs_t next_legs;
   ctb_code_t fld;
   logic      fld_en;

   assign fld    = next_cur[`CTB_POS_FLD_MSB:`CTB_POS_FLD_LSB];
   assign fld_en = (fld != `CTB_CODE_OFF) && (fld != `CTB_CODE_RSVD);

   always_comb begin
      next_cur     = cur;
      next_ack_tgl = ack_tgl;
      if (req_sync != ack_tgl) begin
         next_cur     = cfg_hold;
         next_ack_tgl = req_sync;
      end
      if (lrst) begin
         next_cur     = `CTB_CFG_RST;
         next_ack_tgl = 1'b0;
      end
   end

   // Power-down and self refresh do not enter this decode: the terminating rank
   // must keep loading the shared bus for the other ranks.
   // The strap is used as sampled, with no power-state gating.
   always_comb begin
      next_ca_on = 1'b0;
      next_ck_on = 1'b0;
      next_cs_on = 1'b0;
      if (fld_en) begin
         if (strap_s) begin
            next_ck_on = 1'b1;
            next_cs_on = 1'b1;
            next_ca_on = ~next_cur[`CTB_POS_DIS];
         end else begin
            next_ca_on = 1'b0;
            next_ck_on = next_cur[`CTB_POS_CK];
            next_cs_on = next_cur[`CTB_POS_CS];
         end
      end
      if (lrst) begin
         next_ca_on = 1'b0;
         next_ck_on = 1'b0;
         next_cs_on = 1'b0;
      end
   end

   // One select line per strength; code n drives leg n-1 while CA termination is on
   genvar gi;
   generate
      for (gi = 0; gi < `CTB_LEGS; gi++) begin : g_leg
         assign next_legs[gi] = next_ca_on && (fld == 3'(gi + 1));
      end
   endgenerate

   always_ff @(posedge ca_clk) begin
      cur             <= next_cur;
      ack_tgl         <= next_ack_tgl;
      ca_term_on      <= next_ca_on;
      ck_term_on      <= next_ck_on;
      cs_term_on      <= next_cs_on;
      ca_term_leg_sel <= next_legs;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Checks

   a_legs_match: assert property (@(posedge ca_clk) disable iff (lrst)
      ca_term_on |-> ($onehot(ca_term_leg_sel) && ca_term_leg_sel[$past(fld) - 3'h1]))
      else $error("Leg select does not match the strength code");

   a_code_40_leg: assert property (@(posedge ca_clk) disable iff (lrst)
      (next_cur == 6'h06 && strap_s) |=> (ca_term_leg_sel == 6'h20))
      else $error("Code 110 did not select the 40 ohm leg");

   a_off_disabled: assert property (@(posedge ca_clk) disable iff (lrst)
      (fld == `CTB_CODE_OFF) |=> (!ca_term_on && !ck_term_on && !cs_term_on && ca_term_leg_sel == 6'h00))
      else $error("Termination on while the field is disabled");

   a_rsvd_all_off: assert property (@(posedge ca_clk) disable iff (lrst)
      (fld == `CTB_CODE_RSVD) |=> (!ca_term_on && !ck_term_on && !cs_term_on))
      else $error("Termination on with the reserved code");

   a_pd_keeps_on: assert property (@(posedge ca_clk) disable iff (lrst)
      (ca_term_on && (pd_s || sr_s) && next_cur == cur && $stable(strap_s)) |=> ca_term_on)
      else $error("CA termination dropped in a power-down state");

   a_strap_low_off: assert property (@(posedge ca_clk) disable iff (lrst)
      !strap_s |=> !ca_term_on)
      else $error("CA terminated with the strap low");

   a_strap_high_on: assert property (@(posedge ca_clk) disable iff (lrst)
      (strap_s && fld_en && !next_cur[`CTB_POS_DIS]) |=> (ca_term_on && ck_term_on && cs_term_on))
      else $error("CA not terminated with the strap high and field enabled");

   a_force_follow: assert property (@(posedge ca_clk) disable iff (lrst)
      (!strap_s && fld_en) |=> (ck_term_on == $past(next_cur[`CTB_POS_CK]) &&
                                cs_term_on == $past(next_cur[`CTB_POS_CS])))
      else $error("Clock or select termination ignores its force bit");

   a_pd_entry_hold: assert property (@(posedge ca_clk) disable iff (lrst)
      ($rose(pd_s) && strap_s && fld_en && next_cur == cur) ##1 (pd_s && strap_s && next_cur == cur)
         |=> (ck_term_on && cs_term_on))
      else $error("Termination changed on power-down entry");

   a_xfer_bound: assert property (@(posedge mclk) disable iff (rst)
      $rose(cfg_busy) |-> ##[1:100] !cfg_busy)
      else $error("Configuration transfer did not complete");

   a_legs_idle_off: assert property (@(posedge ca_clk) disable iff (lrst)
      !ca_term_on |-> (ca_term_leg_sel == 6'h00))
      else $error("Leg selected while CA termination is off");

   a_strap_low_legs: assert property (@(posedge ca_clk) disable iff (lrst)
      !strap_s |=> (ca_term_leg_sel == 6'h00))
      else $error("Strength leg selected with the strap low");

   a_rsvd_no_legs: assert property (@(posedge ca_clk) disable iff (lrst)
      (fld == `CTB_CODE_RSVD) |=> (ca_term_leg_sel == 6'h00))
      else $error("Strength leg selected with the reserved code");

   a_strap_dis_ca: assert property (@(posedge ca_clk) disable iff (lrst)
      (strap_s && fld_en && next_cur[`CTB_POS_DIS]) |=> (!ca_term_on && ck_term_on && cs_term_on))
      else $error("CA disable bit not honoured with the strap high");

   a_sr_keeps_on: assert property (@(posedge ca_clk) disable iff (lrst)
      (sr_s && strap_s && fld_en && next_cur == cur) |=> (ck_term_on && cs_term_on))
      else $error("Clock or select termination dropped in self refresh");

   // Reset checks carry no disable so that they watch the reset itself
   a_link_rst_off: assert property (@(posedge ca_clk)
      lrst |=> (!ca_term_on && !ck_term_on && !cs_term_on && ca_term_leg_sel == 6'h00))
      else $error("Termination on after link reset");

   a_core_rst_clear: assert property (@(posedge mclk)
      rst |=> (!cfg_busy && cfg_hold == `CTB_CFG_RST))
      else $error("Configuration word not cleared by reset");

   // Crossing checks: the link side copies the held word on any ca_clk edge once
   // the request arrives, so the word must not move while a transfer is open.
   a_hold_steady: assert property (@(posedge mclk) disable iff (rst)
      cfg_busy |=> $stable(cfg_hold))
      else $error("Held configuration word changed during a transfer");

   a_busy_starts: assert property (@(posedge mclk) disable iff (rst)
      (!cfg_busy && cfg_word != cfg_hold) |=> cfg_busy)
      else $error("Configuration change did not start a transfer");

   a_busy_ends: assert property (@(posedge mclk) disable iff (rst)
      (cfg_busy && ack_sync == req_tgl) |=> !cfg_busy)
      else $error("Transfer stayed open after the acknowledge");

   a_link_takes_word: assert property (@(posedge ca_clk) disable iff (lrst)
      (req_sync != ack_tgl) |=> (cur == $past(cfg_hold) && ack_tgl == $past(req_sync)))
      else $error("Link side did not take the offered word");

endmodule : ctb_ca_term_ctrl

//--- rtl/ctb_consts.svh
// Constants for the command bus termination control block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef CTB_CONSTS_SVH
`define CTB_CONSTS_SVH

// Termination strength codes
`define CTB_CODE_OFF    3'h0
`define CTB_CODE_240    3'h1
`define CTB_CODE_120    3'h2
`define CTB_CODE_80     3'h3
`define CTB_CODE_60     3'h4
`define CTB_CODE_48     3'h5
`define CTB_CODE_40     3'h6
`define CTB_CODE_RSVD   3'h7

// Number of selectable strengths
`define CTB_LEGS        6

// Layout of the configuration word carried across the clock boundary
`define CTB_WORD_W      6
`define CTB_POS_FLD_MSB 2
`define CTB_POS_FLD_LSB 0
`define CTB_POS_CK      3
`define CTB_POS_CS      4
`define CTB_POS_DIS     5

// Reset value of the configuration word: termination disabled
`define CTB_CFG_RST     6'h00

`endif

//--- rtl/ctb_pkg.sv
// Types shared by the command bus termination control block.
// Assumes ctb_consts.svh is on the include path.
`include "ctb_consts.svh"

package ctb_pkg;

   typedef logic [2:0]             ctb_code_t;
   typedef logic [`CTB_WORD_W-1:0] ctb_word_t;
   typedef logic [`CTB_LEGS-1:0]   ctb_legs_t;

   typedef enum logic [1:0] {
      CTB_IDLE = 2'b01,
      CTB_WAIT = 2'b10
   } ctb_xfer_e;

endpackage : ctb_pkg

//--- rtl/ctb_sync2.sv
// Two-stage synchroniser for independent level bits.
// Assumes each bit is a level that holds long enough to be seen; rst is synchronous to clk.
`timescale 1ns/1ps

module ctb_sync2 #(
   parameter int W = 1
) (
   // Destination clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);

   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   always_comb begin
      next_meta = rst ? '0 : d;
      next_q    = rst ? '0 : meta;
   end

   always_ff @(posedge clk) begin
      meta <= next_meta;
      q    <= next_q;
   end

endmodule : ctb_sync2

//--- verification/ctb_ctrl_model.sv
// Memory controller model: makes the command bus clock and drives the power-state pins.
// Assumes the bench requests power states; the pins change only just after ca_clk edges.
`timescale 1ns/1ps

module ctb_ctrl_model (
   // Requests from the bench
   input  wire logic pd_req,
   input  wire logic sr_req,
   // Command bus clock and power-state pins
   output logic      ca_clk,
   output logic      power_down,
   output logic      self_refresh
);
   // Free running so the link side sees reset; phase unrelated to mclk
   initial begin
      ca_clk = 1'b0;
      power_down = 1'b0;
      self_refresh = 1'b0;
      #37;
      forever #80 ca_clk = ~ca_clk;
   end

   // Never starts a calibration, so none overlaps, none runs in power-down or under a field change
   // Single rank with a fixed pull-up point: no training order to keep, no recalibration owed
   always @(posedge ca_clk) begin
      power_down <= pd_req | sr_req;
      self_refresh <= sr_req;
   end
endmodule : ctb_ctrl_model

//--- verification/test_ctb_ca_term_ctrl.sv
// Testbench for the command bus termination control: drives fields and pads, checks states.
// Assumes the controller model supplies ca_clk and the power-state pins.
`timescale 1ns/1ps
`include "ctb_consts.svh"

module test_ctb_ca_term_ctrl;
   import ctb_pkg::*;
   logic      mclk, rst, ck_f, cs_f, dis, strap, pd_req, sr_req;
   ctb_code_t code;
   logic      ca_clk, power_down, self_refresh, cfg_busy, ca_on, ck_on, cs_on;
   ctb_legs_t legs;
   int        err_count, comparisons, cycles;

   ctb_ctrl_model ctrl (.pd_req(pd_req), .sr_req(sr_req), .ca_clk(ca_clk),
                        .power_down(power_down), .self_refresh(self_refresh));
   ctb_ca_term_ctrl dut (.mclk(mclk), .rst(rst), .ca_term_value_field(code), .clock_term_force(ck_f),
                         .chip_select_term_force(cs_f), .ca_term_disable(dis), .ca_clk(ca_clk),
                         .ca_term_strap(strap), .power_down(power_down), .self_refresh(self_refresh),
                         .cfg_busy(cfg_busy), .ca_term_on(ca_on), .ck_term_on(ck_on),
                         .cs_term_on(cs_on), .ca_term_leg_sel(legs));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test

   // Expected states worked out from field, forces, disable and strap
   task automatic check(input ctb_code_t c, input logic k, s, d, st);
      logic       en, e_ca;
      logic [8:0] exp_v, got;
      en = (c != `CTB_CODE_OFF) && (c != `CTB_CODE_RSVD);
      e_ca = en & st & ~d;
      exp_v = {e_ca, en & (st | k), en & (st | s), e_ca ? ctb_legs_t'(6'h01 << (c - 3'h1)) : 6'h00};
      got = {ca_on, ck_on, cs_on, legs};
      comparisons++;
      if (got !== exp_v) begin
         err_count++;
         $display("wrong value term states, code %0d: expected %b, seen %b", c, exp_v, got);
      end
   endtask : check

   // Drive all inputs, wait for the crossing and the pad synchronisers, then check
   task automatic step(input ctb_code_t c, input logic k, s, d, st, p, r);
      int n;
      @(negedge mclk);
      {code, ck_f, cs_f, dis, strap, pd_req, sr_req} = {c, k, s, d, st, p, r};
      n = 0;
      repeat (4) @(negedge mclk);
      while (cfg_busy !== 1'b0 && n < 100) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 100) begin
         err_count++;
         $display("wrong value cfg_busy: expected 0, seen %b", cfg_busy);
      end
      // Pad path needs three ca_clk edges; one more covers the power-state pins
      repeat (5) @(posedge ca_clk);
      @(negedge mclk);
      check(c, k, s, d, st);
   endtask : step

   ////////////////////////////////////////////////////////////////////////////////
   initial mclk = 1'b0;
   always #10 mclk = ~mclk;

   // Hang guard: a few dozen steps of at most a few hundred cycles each
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         end_of_test();
      end
   end

   initial begin
      {code, ck_f, cs_f, dis, pd_req, sr_req} = '0;
      strap = 1'b1;
      rst = 1'b1;
      err_count = 0;
      comparisons = 0;
      cycles = 0;
      // Longer than 24 cycles: the link side must see reset on three ca_clk edges
      repeat (30) @(negedge mclk);
      rst = 1'b0;
      step(`CTB_CODE_OFF, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      for (int i = 0; i < 8; i++) begin
         step(3'(i), 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      end
      // All 16 force, disable and strap settings at the 80 ohm strength; no power states between them
      for (int i = 0; i < 16; i++) begin
         step(`CTB_CODE_80, i[0], i[1], i[2], i[3], 1'b0, 1'b0);
      end
      step(`CTB_CODE_OFF, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      step(`CTB_CODE_RSVD, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      // Settle the strength first so that power-down entry below changes nothing else
      step(`CTB_CODE_40, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      step(`CTB_CODE_40, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      step(`CTB_CODE_40, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      step(`CTB_CODE_240, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      // Second change lands while the first is still crossing; the latest must win
      @(negedge mclk);
      code = `CTB_CODE_120;
      repeat (2) @(negedge mclk);
      code = `CTB_CODE_48;
      step(`CTB_CODE_48, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      end_of_test();
   end
endmodule : test_ctb_ca_term_ctrl
